// *** src/wave_capture_pkg.sv ***
// Shared constants and types for the embedded waveform capture block
package wave_capture_pkg;
    // Capture memory
    localparam int CAP_DEPTH = 4096;
    localparam int AW = 12;
    localparam logic [13:0] CAP_DEPTH_W = 14'(CAP_DEPTH);
    localparam logic [AW-1:0] LAST_ENTRY = 12'hFFF;

    // Register offsets
    localparam logic [11:0] OFS_TRIG_POS = 12'h0724;
    localparam logic [11:0] OFS_CAP_CTRL = 12'h0730;
    localparam logic [11:0] OFS_WAVE_DATA = 12'h0734;
    localparam logic [11:0] OFS_SAMPLE_RATE = 12'h0738;
    localparam logic [11:0] OFS_SRC_SEL = 12'h073C;
    localparam logic [11:0] OFS_REWIND = 12'h0748;
    localparam logic [11:0] OFS_DUMP_RATE = 12'h074C;
    localparam logic [11:0] OFS_DUMP_START = 12'h0750;
    localparam logic [11:0] OFS_FREE_RUN = 12'h0754;

    // Field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_ROUTE_BIT = 1;
    localparam int CTRL_LEFT_LSB = 16;
    localparam int SEL_PORT_LSB = 0;
    localparam int SEL_VIEW_LSB = 8;
    localparam int SEL_GPIO_MEM_BIT = 16;
    localparam int SEL_USER_BIT = 17;
    localparam int SEL_PORTOK_BIT = 18;
    localparam int CMD_BIT = 0;

    // Reset values
    localparam logic [13:0] CYCLES_LEFT_RST = 14'h3FFF;
    localparam logic [6:0] TRIG_POS_RST = 7'h20;

    // Rates; the fastest documented rate maps onto one core tick
    localparam int FASTEST_RATE_MHZ = 500;
    localparam int RATE0_MHZ = 500;
    localparam int RATE1_MHZ = 250;
    localparam int RATE2_MHZ = 125;
    localparam int RATE_DIV0 = FASTEST_RATE_MHZ / RATE0_MHZ;
    localparam int RATE_DIV1 = FASTEST_RATE_MHZ / RATE1_MHZ;
    localparam int RATE_DIV2 = FASTEST_RATE_MHZ / RATE2_MHZ;

    // Probe selections used when software does not choose
    localparam logic [5:0] DEFAULT_PORT = 6'h00;
    localparam logic [4:0] DEFAULT_VIEW = 5'h00;
    localparam logic [5:0] FREE_RUN_PORT = 6'h00;
    localparam logic [4:0] FREE_RUN_VIEW = 5'h10;

    typedef enum logic [1:0] {
        CAP_IDLE = 2'b00,
        CAP_ARMED = 2'b01,
        CAP_POST = 2'b11,
        CAP_DONE = 2'b10
    } cap_state_t;
endpackage : wave_capture_pkg

// *** src/rate_pulse_gen.sv ***
// One-cycle rate enable derived from a 4-bit rate code
module rate_pulse_gen (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Rate selection and enable out
    input wire logic [3:0] rate_code,
    output logic tick
);
    import wave_capture_pkg::*;

    logic [2:0] cnt_q, cnt_d, last;
    logic tick_d;

    always_comb begin
        unique case (rate_code)
            4'h0: last = 3'(RATE_DIV0 - 1);
            4'h1: last = 3'(RATE_DIV1 - 1);
            default: last = 3'(RATE_DIV2 - 1);
        endcase
        // >= so that a code change mid-count cannot strand the counter
        tick_d = (cnt_q >= last);
        cnt_d = tick_d ? 3'h0 : cnt_q + 3'h1;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 3'h0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule : rate_pulse_gen

// *** src/two_entry_buffer.sv ***
// Two-entry valid/ready buffer; registered outputs, no word lost on stall
module two_entry_buffer #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    logic skid_v_q, skid_v_d, out_v_d;
    logic [WIDTH-1:0] skid_q, skid_d, out_d;
    logic push, pop;

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        skid_v_d = skid_v_q;
        skid_d = skid_q;
        out_v_d = out_valid;
        out_d = out_data;
        if (skid_v_q) begin
            if (pop) begin
                out_d = skid_q;
                skid_v_d = 1'b0;
            end
        end else if (!out_valid || pop) begin
            out_v_d = push;
            if (push) begin
                out_d = in_data;
            end
        end else if (push) begin
            skid_d = in_data;
            skid_v_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            skid_v_q <= 1'b0;
            skid_q <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
            in_ready <= 1'b1;
        end else begin
            skid_v_q <= skid_v_d;
            skid_q <= skid_d;
            out_valid <= out_v_d;
            out_data <= out_d;
            in_ready <= !skid_v_d;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    stall_holds_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("buffer output changed while stalled");
endmodule : two_entry_buffer

// *** src/embedded_waveform_capture.sv ***
// Embedded waveform capture memory with register port, replay and GPIO stream
module embedded_waveform_capture (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Register access port
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic [11:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_rvalid,
    output logic [31:0] cfg_rdata,
    // Probe bus of the switch core
    output logic [5:0] probe_port_sel,
    output logic [4:0] probe_view_sel,
    input wire logic [31:0] probe_data,
    input wire logic trigger_hit,
    // Port status indicators
    input wire logic [7:0] link_ok_n,
    input wire logic [7:0] err_ok_n,
    output logic [7:0] port_ok_n,
    // Debug GPIO stream
    input wire logic gpio_ready_pin,
    output logic gpio_valid,
    output logic [31:0] gpio_data
);
    import wave_capture_pkg::*;

    // Software-visible state
    logic trig_start_q, trig_start_d, route_en_q, route_en_d;
    logic [6:0] trig_pos_q, trig_pos_d;
    logic [3:0] samp_rate_q, samp_rate_d, dump_rate_q, dump_rate_d;
    logic [5:0] port_sel_q, port_sel_d;
    logic [4:0] view_sel_q, view_sel_d;
    logic gpio_mem_q, gpio_mem_d, user_mode_q, user_mode_d;
    logic portok_err_q, portok_err_d;
    logic dump_q, dump_d, free_run_q, free_run_d;
    logic [AW-1:0] rd_ptr_q, rd_ptr_d;
    logic cfg_rvalid_d;
    logic [31:0] cfg_rdata_d;

    // Capture and replay state
    cap_state_t state_q, state_d;
    logic [AW-1:0] wr_ptr_q, wr_ptr_d, base_q, base_d, rp_q, rp_d;
    logic [13:0] left_q, left_d;
    logic [5:0] probe_port_d;
    logic [4:0] probe_view_d;
    logic [7:0] port_ok_d;

    logic [31:0] mem [CAP_DEPTH];
    logic wr, rd, mem_we, cap_done, dump_done, src_mem, rp_active;
    logic samp_tick, rp_tick, buf_in_valid, buf_in_ready;
    logic [31:0] buf_in_data, rd_word, rp_word;
    logic [13:0] post_len;
    logic [AW-1:0] rp_addr;
    logic gpio_rdy_s1_q, gpio_rdy_s2_q;

    assign wr = cfg_req && cfg_we;
    assign rd = cfg_req && !cfg_we;
    assign rd_word = mem[base_q + rd_ptr_q];
    assign rp_addr = free_run_q ? rp_q : base_q + rp_q;
    assign rp_word = mem[rp_addr];
    // Position in 1/128 steps of the memory; 7Fh leaves 32 entries after trigger
    assign post_len = CAP_DEPTH_W - {2'h0, trig_pos_q, 5'h00};

    rate_pulse_gen sample_rate_gen (
        .core_clk(core_clk),
        .nrst(nrst),
        .rate_code(samp_rate_q),
        .tick(samp_tick)
    );

    rate_pulse_gen replay_rate_gen (
        .core_clk(core_clk),
        .nrst(nrst),
        .rate_code(dump_rate_q),
        .tick(rp_tick)
    );

    two_entry_buffer #(
        .WIDTH(32)
    ) gpio_buf (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(buf_in_valid),
        .in_data(buf_in_data),
        .in_ready(buf_in_ready),
        .out_valid(gpio_valid),
        .out_data(gpio_data),
        .out_ready(gpio_rdy_s2_q)
    );

    // Register file: writes, hardware clears, read mux
    always_comb begin
        trig_start_d = trig_start_q;
        route_en_d = route_en_q;
        trig_pos_d = trig_pos_q;
        samp_rate_d = samp_rate_q;
        port_sel_d = port_sel_q;
        view_sel_d = view_sel_q;
        gpio_mem_d = gpio_mem_q;
        user_mode_d = user_mode_q;
        portok_err_d = portok_err_q;
        dump_rate_d = dump_rate_q;
        dump_d = dump_q;
        free_run_d = free_run_q;
        rd_ptr_d = rd_ptr_q;
        cfg_rvalid_d = rd;
        cfg_rdata_d = 32'h0000_0000;
        // Hardware clears first so a same-cycle software write wins
        if (cap_done) begin
            trig_start_d = 1'b0;
        end
        if (dump_done) begin
            dump_d = 1'b0;
        end
        if (wr) begin
            case (cfg_addr)
                OFS_TRIG_POS: trig_pos_d = cfg_wdata[6:0];
                OFS_CAP_CTRL: begin
                    trig_start_d = cfg_wdata[CTRL_START_BIT];
                    route_en_d = cfg_wdata[CTRL_ROUTE_BIT];
                end
                OFS_SAMPLE_RATE: samp_rate_d = cfg_wdata[3:0];
                OFS_SRC_SEL: begin
                    port_sel_d = cfg_wdata[SEL_PORT_LSB +: 6];
                    view_sel_d = cfg_wdata[SEL_VIEW_LSB +: 5];
                    gpio_mem_d = cfg_wdata[SEL_GPIO_MEM_BIT];
                    user_mode_d = cfg_wdata[SEL_USER_BIT];
                    portok_err_d = cfg_wdata[SEL_PORTOK_BIT];
                end
                OFS_REWIND: begin
                    if (cfg_wdata[CMD_BIT]) begin
                        rd_ptr_d = '0;
                    end
                end
                OFS_DUMP_RATE: dump_rate_d = cfg_wdata[3:0];
                OFS_DUMP_START: dump_d = cfg_wdata[CMD_BIT];
                OFS_FREE_RUN: free_run_d = cfg_wdata[CMD_BIT];
                default: ;
            endcase
        end
        if (rd) begin
            case (cfg_addr)
                OFS_TRIG_POS: cfg_rdata_d[6:0] = trig_pos_q;
                OFS_CAP_CTRL: begin
                    cfg_rdata_d[CTRL_START_BIT] = trig_start_q;
                    cfg_rdata_d[CTRL_ROUTE_BIT] = route_en_q;
                    cfg_rdata_d[CTRL_LEFT_LSB +: 14] = left_q;
                end
                OFS_WAVE_DATA: begin
                    cfg_rdata_d = rd_word;
                    rd_ptr_d = rd_ptr_q + 12'h001;
                end
                OFS_SAMPLE_RATE: cfg_rdata_d[3:0] = samp_rate_q;
                OFS_SRC_SEL: begin
                    cfg_rdata_d[SEL_PORT_LSB +: 6] = port_sel_q;
                    cfg_rdata_d[SEL_VIEW_LSB +: 5] = view_sel_q;
                    cfg_rdata_d[SEL_GPIO_MEM_BIT] = gpio_mem_q;
                    cfg_rdata_d[SEL_USER_BIT] = user_mode_q;
                    cfg_rdata_d[SEL_PORTOK_BIT] = portok_err_q;
                end
                OFS_DUMP_RATE: cfg_rdata_d[3:0] = dump_rate_q;
                OFS_DUMP_START: cfg_rdata_d[CMD_BIT] = dump_q;
                OFS_FREE_RUN: cfg_rdata_d[CMD_BIT] = free_run_q;
                default: ; // Rewind and unmapped read as zero
            endcase
        end
    end

    // Capture sequencing
    always_comb begin
        state_d = state_q;
        wr_ptr_d = wr_ptr_q;
        left_d = left_q;
        base_d = base_q;
        mem_we = 1'b0;
        cap_done = 1'b0;
        if (!route_en_q) begin
            state_d = CAP_IDLE;
            left_d = CYCLES_LEFT_RST;
        end else if (free_run_q) begin
            state_d = CAP_IDLE;
            left_d = CYCLES_LEFT_RST;
            mem_we = samp_tick;
            if (samp_tick) begin
                wr_ptr_d = wr_ptr_q + 12'h001;
            end
        end else begin
            unique case (state_q)
                CAP_IDLE, CAP_DONE: begin
                    if (trig_start_q) begin
                        state_d = CAP_ARMED;
                        wr_ptr_d = '0;
                        left_d = CYCLES_LEFT_RST;
                    end
                end
                CAP_ARMED: begin
                    mem_we = samp_tick;
                    if (samp_tick) begin
                        wr_ptr_d = wr_ptr_q + 12'h001;
                    end
                    if (trigger_hit) begin
                        state_d = CAP_POST;
                        left_d = post_len;
                    end
                end
                CAP_POST: begin
                    mem_we = samp_tick;
                    if (samp_tick) begin
                        wr_ptr_d = wr_ptr_q + 12'h001;
                        left_d = left_q - 14'h0001;
                        if (left_q == 14'h0001) begin
                            state_d = CAP_DONE;
                            base_d = wr_ptr_q + 12'h001;
                            cap_done = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Replay and GPIO source selection
    always_comb begin
        src_mem = gpio_mem_q || dump_q || free_run_q;
        rp_active = dump_q || free_run_q;
        buf_in_valid = rp_tick && (!src_mem || rp_active);
        buf_in_data = src_mem ? rp_word : probe_data;
        rp_d = rp_active ? rp_q : '0;
        dump_done = 1'b0;
        // A refused word is retried on the next replay tick
        if (src_mem && rp_active && buf_in_valid && buf_in_ready) begin
            rp_d = rp_q + 12'h001;
            dump_done = dump_q && !free_run_q && (rp_q == LAST_ENTRY);
        end
    end

    // Probe selection and port status
    always_comb begin
        probe_port_d = DEFAULT_PORT;
        probe_view_d = DEFAULT_VIEW;
        if (free_run_q) begin
            probe_port_d = FREE_RUN_PORT;
            probe_view_d = FREE_RUN_VIEW;
        end else if (user_mode_q) begin
            probe_port_d = port_sel_q;
            probe_view_d = view_sel_q;
        end
        port_ok_d = portok_err_q ? err_ok_n : link_ok_n;
    end

    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem[wr_ptr_q] <= probe_data;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            trig_start_q <= 1'b0;
            route_en_q <= 1'b0;
            trig_pos_q <= TRIG_POS_RST;
            samp_rate_q <= 4'h0;
            port_sel_q <= 6'h00;
            view_sel_q <= 5'h00;
            gpio_mem_q <= 1'b0;
            user_mode_q <= 1'b0;
            portok_err_q <= 1'b0;
            dump_rate_q <= 4'h0;
            dump_q <= 1'b0;
            free_run_q <= 1'b0;
            rd_ptr_q <= '0;
            cfg_rvalid <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
            state_q <= CAP_IDLE;
            wr_ptr_q <= '0;
            left_q <= CYCLES_LEFT_RST;
            base_q <= '0;
            rp_q <= '0;
            probe_port_sel <= DEFAULT_PORT;
            probe_view_sel <= DEFAULT_VIEW;
            port_ok_n <= 8'hFF;
            gpio_rdy_s1_q <= 1'b0;
            gpio_rdy_s2_q <= 1'b0;
        end else begin
            trig_start_q <= trig_start_d;
            route_en_q <= route_en_d;
            trig_pos_q <= trig_pos_d;
            samp_rate_q <= samp_rate_d;
            port_sel_q <= port_sel_d;
            view_sel_q <= view_sel_d;
            gpio_mem_q <= gpio_mem_d;
            user_mode_q <= user_mode_d;
            portok_err_q <= portok_err_d;
            dump_rate_q <= dump_rate_d;
            dump_q <= dump_d;
            free_run_q <= free_run_d;
            rd_ptr_q <= rd_ptr_d;
            cfg_rvalid <= cfg_rvalid_d;
            cfg_rdata <= cfg_rdata_d;
            state_q <= state_d;
            wr_ptr_q <= wr_ptr_d;
            left_q <= left_d;
            base_q <= base_d;
            rp_q <= rp_d;
            probe_port_sel <= probe_port_d;
            probe_view_sel <= probe_view_d;
            port_ok_n <= port_ok_d;
            gpio_rdy_s1_q <= gpio_ready_pin;
            gpio_rdy_s2_q <= gpio_rdy_s1_q;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    left_idle_a: assert property (state_q == CAP_IDLE |-> left_q == CYCLES_LEFT_RST)
        else $error("cycles left not all ones while idle");
    route_gate_a: assert property (!route_en_q |-> !mem_we)
        else $error("memory written while routing disabled");
    read_data_a: assert property (rd && cfg_addr == OFS_WAVE_DATA |=> cfg_rvalid && cfg_rdata == $past(rd_word))
        else $error("waveform read returned wrong word");
    read_advance_a: assert property (rd && cfg_addr == OFS_WAVE_DATA |=> rd_ptr_q == $past(rd_ptr_q) + 12'h001)
        else $error("read pointer did not advance by one");
    fast_sample_a: assert property ($past(nrst) && samp_rate_q == 4'h0 && $past(samp_rate_q) == 4'h0
        |-> samp_tick)
        else $error("full rate sampling missed a cycle");
    gpio_live_a: assert property (buf_in_valid && !src_mem |-> buf_in_data == probe_data)
        else $error("live GPIO source not the probe bus");
    user_sel_a: assert property (user_mode_q && !free_run_q |=> probe_port_sel == $past(port_sel_q)
        && probe_view_sel == $past(view_sel_q))
        else $error("user probe selection not applied");
    port_ok_a: assert property (portok_err_q |=> port_ok_n == $past(err_ok_n))
        else $error("port-ok not driven from error status");
    rewind_a: assert property (wr && cfg_addr == OFS_REWIND && cfg_wdata[CMD_BIT] |=> rd_ptr_q == '0)
        else $error("rewind did not reset read pointer");
    rewind_zero_a: assert property (rd && cfg_addr == OFS_REWIND |=> cfg_rdata == 32'h0000_0000)
        else $error("rewind register read nonzero");
    post_len_a: assert property (route_en_q && !free_run_q && state_q == CAP_ARMED && trigger_hit
        |=> state_q == CAP_POST && left_q == CAP_DEPTH_W - {2'h0, $past(trig_pos_q), 5'h00})
        else $error("post-trigger length wrong");
    dump_order_a: assert property (dump_q && !free_run_q && buf_in_valid && buf_in_ready
        |=> rp_q == $past(rp_q) + 12'h001 || !dump_q)
        else $error("dump did not advance by one entry");
endmodule : embedded_waveform_capture

// *** bench/gpio_analyzer_model.sv ***
// Probe source and GPIO analyzer standing at the far side of the capture block
module gpio_analyzer_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Probe side
    input wire logic [5:0] probe_port_sel,
    input wire logic [4:0] probe_view_sel,
    output logic [31:0] probe_data,
    // GPIO side
    input wire logic stall,
    input wire logic rec,
    input wire logic gpio_valid,
    input wire logic [31:0] gpio_data,
    output logic gpio_ready_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [20:0] cnt_q;
    logic [1:0] rdy_q;
    logic [31:0] words[$];
    // Select rides in the top bits, so a wrong port or view shows in the data
    assign probe_data = {probe_port_sel, probe_view_sel, cnt_q};
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 21'h0;
            rdy_q <= 2'h0;
            gpio_ready_pin <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 21'h1;
            gpio_ready_pin <= !stall;
            // Mirrors the two-stage pin synchroniser inside the block
            rdy_q <= {rdy_q[0], gpio_ready_pin};
            if (rec && gpio_valid && rdy_q[1]) begin
                words.push_back(gpio_data);
            end
        end
    end
endmodule : gpio_analyzer_model

// *** bench/embedded_waveform_capture_tb.sv ***
// Self-checking bench for the embedded waveform capture block
module embedded_waveform_capture_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import wave_capture_pkg::*;
    logic core_clk, nrst, cfg_req, cfg_we, cfg_rvalid, trigger_hit, gpio_ready_pin, gpio_valid, stall, rec;
    logic [11:0] cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata, probe_data, gpio_data, r, first_q;
    logic [5:0] probe_port_sel;
    logic [4:0] probe_view_sel;
    logic [7:0] link_ok_n, err_ok_n, port_ok_n;
    int err_total, cmp_count;

    embedded_waveform_capture u_embedded_waveform_capture (.core_clk(core_clk), .nrst(nrst), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata),
        .probe_port_sel(probe_port_sel), .probe_view_sel(probe_view_sel), .probe_data(probe_data),
        .trigger_hit(trigger_hit), .link_ok_n(link_ok_n), .err_ok_n(err_ok_n), .port_ok_n(port_ok_n),
        .gpio_ready_pin(gpio_ready_pin), .gpio_valid(gpio_valid), .gpio_data(gpio_data));
    gpio_analyzer_model u_gpio_analyzer_model (.core_clk(core_clk), .nrst(nrst), .probe_port_sel(probe_port_sel),
        .probe_view_sel(probe_view_sel), .probe_data(probe_data), .stall(stall), .rec(rec),
        .gpio_valid(gpio_valid), .gpio_data(gpio_data), .gpio_ready_pin(gpio_ready_pin));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cfg_req <= 1'b1;
        cfg_we <= we;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge core_clk);
        cfg_req <= 1'b0;
        #1;
        r = cfg_rdata;
        if (!we) chk("read valid", 32'h1, {31'h0, cfg_rvalid});
    endtask : acc

    // Bounded poll until bit 0 of a self-clearing register drops
    task automatic wait_clear(input logic [11:0] a);
        int n;
        n = 0;
        do begin
            acc(1'b0, a, 32'h0);
            n++;
        end while (r[0] !== 1'b0 && n < 12000);
        chk("start bit clear", 32'h0, {31'h0, r[0]});
    endtask : wait_clear

    task automatic t_reset;
        logic [11:0] a[9] = '{OFS_TRIG_POS, OFS_CAP_CTRL, OFS_SAMPLE_RATE, OFS_SRC_SEL, OFS_REWIND,
            OFS_DUMP_RATE, OFS_DUMP_START, OFS_FREE_RUN, 12'h0740};
        logic [31:0] e[9] = '{32'h0000_0020, 32'h3FFF_0000, 0, 0, 0, 0, 0, 0, 0};
        foreach (a[i]) begin
            acc(1'b0, a[i], 32'h0);
            chk("reset value", e[i], r);
        end
        chk("port ok", {24'h0, link_ok_n}, {24'h0, port_ok_n});
        $display("test reset done");
    endtask : t_reset

    task automatic t_select;
        acc(1'b1, OFS_SRC_SEL, 32'hFFFF_FFFF);
        acc(1'b0, OFS_SRC_SEL, 32'h0);
        chk("select reg", 32'h0007_1F3F, r);
        repeat (2) @(posedge core_clk);
        #1;
        chk("port sel", 32'h3F, {26'h0, probe_port_sel});
        chk("view sel", 32'h1F, {27'h0, probe_view_sel});
        chk("port ok", {24'h0, err_ok_n}, {24'h0, port_ok_n});
        chk("gpio live stopped", 32'h0, {31'h0, gpio_valid});
        acc(1'b1, OFS_SAMPLE_RATE, 32'hFFFF_FFFF);
        acc(1'b0, OFS_SAMPLE_RATE, 32'h0);
        chk("rate reg", 32'hF, r);
        acc(1'b1, OFS_REWIND, 32'hFFFF_FFFF);
        acc(1'b0, OFS_REWIND, 32'h0);
        chk("rewind reads", 32'h0, r);
        acc(1'b1, OFS_SRC_SEL, 32'h0);
        repeat (2) @(posedge core_clk);
        #1;
        chk("port ok", {24'h0, link_ok_n}, {24'h0, port_ok_n});
        chk("gpio live again", 32'h1, {31'h0, gpio_valid});
        $display("test select done");
    endtask : t_select

    task automatic t_cap(input logic [3:0] code, input logic [31:0] step);
        logic [31:0] prev;
        acc(1'b1, OFS_TRIG_POS, 32'h0);
        acc(1'b1, OFS_SAMPLE_RATE, {28'h0, code});
        acc(1'b1, OFS_CAP_CTRL, 32'h3);
        repeat (20) @(posedge core_clk);
        trigger_hit <= 1'b1;
        @(posedge core_clk);
        trigger_hit <= 1'b0;
        wait_clear(OFS_CAP_CTRL);
        chk("cycles left", 32'h0, {18'h0, r[29:16]});
        acc(1'b1, OFS_REWIND, 32'h1);
        acc(1'b0, OFS_WAVE_DATA, 32'h0);
        first_q = r;
        repeat (7) begin
            prev = r;
            acc(1'b0, OFS_WAVE_DATA, 32'h0);
            chk("entry step", prev + step, r);
        end
        acc(1'b1, OFS_REWIND, 32'h1);
        acc(1'b0, OFS_WAVE_DATA, 32'h0);
        chk("rewound entry", first_q, r);
        $display("test capture rate %0d done", code);
    endtask : t_cap

    // Analyzer stalls at the start; memory words must be retried, not lost
    task automatic t_dump(input logic [3:0] code, input logic [31:0] step);
        int q[$];
        int bad;
        int div;
        time t0;
        u_gpio_analyzer_model.words.delete();
        div = (code == 4'h0) ? RATE_DIV0 : (code == 4'h1) ? RATE_DIV1 : RATE_DIV2;
        stall <= 1'b1;
        rec <= 1'b1;
        acc(1'b1, OFS_DUMP_RATE, {28'h0, code});
        acc(1'b1, OFS_DUMP_START, 32'h1);
        repeat (40) @(posedge core_clk);
        stall <= 1'b0;
        t0 = $time;
        wait_clear(OFS_DUMP_START);
        // Whole dump paced by the replay rate: 4096 words, small sync and poll slack
        chk("dump cycles", 32'h1, {31'h0, (($time - t0) / 10) inside {[4000 * div : 4200 * div]}});
        repeat (60) @(posedge core_clk);
        rec <= 1'b0;
        @(posedge core_clk);
        q = u_gpio_analyzer_model.words.find_first_index with (item === first_q);
        chk("dump first found", 32'h1, {31'h0, q.size() > 0});
        if (q.size() > 0) begin
            chk("dump length", 32'h1, {31'h0, u_gpio_analyzer_model.words.size() >= q[0] + 4096});
            bad = 0;
            for (int i = 1; i < 4096 && q[0] + i < u_gpio_analyzer_model.words.size(); i++) begin
                if (u_gpio_analyzer_model.words[q[0] + i] !== u_gpio_analyzer_model.words[q[0] + i - 1] + step) bad++;
            end
            chk("dump order errors", 32'h0, bad);
        end
        $display("test dump rate %0d done", code);
    endtask : t_dump

    task automatic t_free_route;
        acc(1'b1, OFS_FREE_RUN, 32'h1);
        repeat (8) @(posedge core_clk);
        #1;
        chk("free view", {27'h0, FREE_RUN_VIEW}, {27'h0, probe_view_sel});
        chk("free port", {26'h0, FREE_RUN_PORT}, {26'h0, probe_port_sel});
        chk("free stream", 32'h1, {31'h0, gpio_valid});
        acc(1'b1, OFS_FREE_RUN, 32'h0);
        acc(1'b1, OFS_REWIND, 32'h1);
        acc(1'b0, OFS_WAVE_DATA, 32'h0);
        first_q = r;
        acc(1'b1, OFS_CAP_CTRL, 32'h1);
        @(posedge core_clk);
        trigger_hit <= 1'b1;
        repeat (50) @(posedge core_clk);
        trigger_hit <= 1'b0;
        acc(1'b0, OFS_CAP_CTRL, 32'h0);
        chk("left unrouted", 32'h3FFF, {18'h0, r[29:16]});
        acc(1'b1, OFS_REWIND, 32'h1);
        acc(1'b0, OFS_WAVE_DATA, 32'h0);
        chk("memory untouched", first_q, r);
        $display("test free run and route done");
    endtask : t_free_route

    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        #900000;
        err_total++;
        $display("watchdog expired");
        test_done();
    end

    initial begin
        {nrst, cfg_req, cfg_we, trigger_hit, stall, rec} = 6'h0;
        cfg_addr = 12'h0;
        cfg_wdata = 32'h0;
        link_ok_n = 8'h5A;
        err_ok_n = 8'hA5;
        err_total = 0;
        cmp_count = 0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_select();
        t_cap(4'h0, 32'h1);
        t_cap(4'h1, 32'h2);
        t_cap(4'h2, 32'h4);
        t_dump(4'h2, 32'h4);
        t_dump(4'h0, 32'h4);
        t_free_route();
        test_done();
    end
endmodule : embedded_waveform_capture_tb
